/* File: include/ilc_params.svh */
`ifndef ILC_PARAMS_SVH
`define ILC_PARAMS_SVH

// register byte addresses on the axi4-lite port
`define ILC_ADDR_PEND 8'h00
`define ILC_ADDR_MASK 8'h04
`define ILC_ADDR_CTRL 8'h08
// the log pointer keeps its printed index; byte address is four times it
`define ILC_LOG_PTR_IDX 8'h05
`define ILC_ADDR_LOG_PTR 8'h14

// reset values
`define ILC_PEND_RESET 16'h0000
`define ILC_MASK_RESET 16'h0000
`define ILC_LOG_PTR_RESET 16'h0000
`define ILC_SYNC_RESET 4'he

// pending and mask layout: hardware failures on top, message events below
`define ILC_HW_MSB 15
`define ILC_HW_LSB 12
`define ILC_MSG_MSB 11
`define ILC_CTRL_LOG_EN 0

// identification word groups
`define ILC_RT_GROUP 12'h780
`define ILC_BC_GROUP 12'h03e
`define ILC_MON_GROUP 12'h001
`define ILC_IDENT_USED 12'hfbf

// ring pointer field and increments
`define ILC_RING_LSB 5
`define ILC_RING_STEP 5'h01
`define ILC_RING_REC 5'h02

// bus answers
`define ILC_RESP_OKAY 2'h0
`define ILC_RESP_SLVERR 2'h2
`define ILC_RDATA_ZERO 32'h0000_0000

`endif

/* File: include/ilc_pkg.sv */
package ilc_pkg;
   // 16-bit register and memory word
   typedef logic [15:0] word_t;
   // position inside the 32-word log ring
   typedef logic [4:0] ring_ptr_t;
   // log writer, gray coded along its path
   typedef enum logic [2:0] {
      LOG_IDLE = 3'h0,
      LOG_REQ = 3'h1,
      LOG_IDENT = 3'h3,
      LOG_SRC = 3'h2,
      LOG_REL = 3'h6
   } log_state_e;
endpackage

/* File: src/ilc_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pins that arrive from outside the clock domain
module ilc_sync2 #(
   parameter int W = 4,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta; // first stage, read only by q

   // both stages load their idle level during reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // ilc_sync2
`default_nettype wire

/* File: src/interrupt_log_controller.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ilc_params.svh"

module interrupt_log_controller #(
   parameter bit ACK_VARIANT = 1'b1 // 1: acknowledge inputs and style select exist
) (
   input wire logic clk,
   input wire logic rstn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // event pulses from the message engine, same clock
   input wire logic [3:0] hw_fail_evt,
   input wire logic [11:0] msg_evt,
   input wire logic remote_terminal_mode,
   input wire logic bus_controller_mode,
   input wire logic monitor_mode,
   input wire logic [15:0] rt_desc_addr,
   input wire logic [15:0] bc_block_addr,
   input wire logic [15:0] mon_count,
   // external memory access
   output logic dma_req_n,
   input wire logic dma_grant_in_n,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_data,
   output logic mem_wr_n,
   // interrupt pins
   output logic hw_fail_irq_n,
   output logic msg_irq_n,
   input wire logic hw_fail_ack_n,
   input wire logic n_a,
   input wire logic irq_output_style_sel
);
   logic [3:0] sync_q; // synchronised pins
   logic grant_s; // dma grant, active low
   logic level_mode; // level style in force
   logic [1:0] ack_s; // [1] failure ack, [0] message ack, active low
   ilc_pkg::word_t pending; // sticky events
   ilc_pkg::word_t mask; // 1 disables the event
   logic log_en; // logging into the ring
   logic [10:0] ring_base; // ring base, upper 11 bits
   ilc_pkg::ring_ptr_t ring_ptr; // next ring word
   ilc_pkg::log_state_e state;
   logic aw_held, w_held; // write halves already taken
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic do_write; // write performed this cycle
   ilc_pkg::word_t wmask; // byte lanes as bit mask
   ilc_pkg::word_t pend_clr;
   logic [11:0] msg_live; // unmasked, loggable events
   logic [3:0] hw_live; // unmasked failures
   logic [1:0] fire; // [1] failure, [0] message
   logic log_done; // record stored and bus released
   logic acc_valid; // a record waits for the writer
   ilc_pkg::word_t acc_ident, acc_src, rec_ident, rec_src;
   logic take; // writer takes the waiting record
   logic irq_q [2]; // output flops, active low

   ilc_sync2 #(.W(4), .RST(`ILC_SYNC_RESET)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .d({dma_grant_in_n, hw_fail_ack_n, n_a, irq_output_style_sel}),
      .q(sync_q)
   );

   assign grant_s = sync_q[3];
   // without the ack variant the acks read as released, outputs pulse
   assign ack_s = ACK_VARIANT ? sync_q[2:1] : 2'h3;
   assign level_mode = ACK_VARIANT && sync_q[0];

   // true when the address names a register
   function automatic logic reg_hit(input logic [7:0] a);
      return (a == `ILC_ADDR_PEND) || (a == `ILC_ADDR_MASK) ||
         (a == `ILC_ADDR_CTRL) || (a == `ILC_ADDR_LOG_PTR);
   endfunction

   // source word by mode and event group; terminal first when concurrent
   function automatic ilc_pkg::word_t pick_source(input logic [11:0] ev);
      if (remote_terminal_mode && ((ev & `ILC_RT_GROUP) != 12'h000 || ev[11]))
         return rt_desc_addr;
      else if (bus_controller_mode && ((ev & `ILC_BC_GROUP) != 12'h000 || ev[11]))
         return bc_block_addr;
      else if (monitor_mode)
         return mon_count;
      else
         return rt_desc_addr;
   endfunction

   // axi handshakes: take each half once, hold off while a reply waits
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign pend_clr = (do_write && wr_addr == `ILC_ADDR_PEND) ? (wr_data[15:0] & wmask) :
      `ILC_PEND_RESET;

   // write channel: address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= `ILC_RDATA_ZERO;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ILC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= reg_hit(wr_addr) ? `ILC_RESP_OKAY : `ILC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one cycle to data, unmapped reads zero with an error
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `ILC_RDATA_ZERO;
         s_axi_rresp <= `ILC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= reg_hit(s_axi_araddr) ? `ILC_RESP_OKAY : `ILC_RESP_SLVERR;
         unique case (s_axi_araddr)
            `ILC_ADDR_PEND: s_axi_rdata <= {16'h0000, pending};
            `ILC_ADDR_MASK: s_axi_rdata <= {16'h0000, mask};
            `ILC_ADDR_CTRL: s_axi_rdata <= {31'h0000_0000, log_en};
            `ILC_ADDR_LOG_PTR: s_axi_rdata <= {16'h0000, ring_base, ring_ptr};
            default: s_axi_rdata <= `ILC_RDATA_ZERO;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // mask and control registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask <= `ILC_MASK_RESET;
         log_en <= 1'b0;
      end else if (do_write && wr_addr == `ILC_ADDR_MASK) begin
         mask <= (mask & ~wmask) | (wr_data[15:0] & wmask);
      end else if (do_write && wr_addr == `ILC_ADDR_CTRL && wr_strb[0]) begin
         log_en <= wr_data[`ILC_CTRL_LOG_EN];
      end
   end

   // pending register: write one to clear, a new event beats the clear
   always_ff @(posedge clk) begin
      if (!rstn)
         pending <= `ILC_PEND_RESET;
      else
         pending <= (pending & ~pend_clr) | {hw_fail_evt, msg_evt};
   end

   // event qualification by the mask
   assign hw_live = hw_fail_evt & ~mask[`ILC_HW_MSB:`ILC_HW_LSB];
   assign msg_live = msg_evt & ~mask[`ILC_MSG_MSB:0] & `ILC_IDENT_USED;
   // failure fires at once, but only while no failure is still pending
   assign fire[1] = (hw_live != 4'h0) &&
      (pending[`ILC_HW_MSB:`ILC_HW_LSB] == 4'h0);
   // message fires after the log record, or at once when not logging
   assign fire[0] = log_done || (!log_en && msg_live != 12'h000);
   assign take = (state == ilc_pkg::LOG_IDLE) && acc_valid;

   // events that land while the writer is busy merge into one record
   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_valid <= 1'b0;
         acc_ident <= `ILC_PEND_RESET;
         acc_src <= `ILC_PEND_RESET;
      end else if (log_en && msg_live != 12'h000) begin
         acc_valid <= 1'b1;
         acc_ident <= {4'h0, ((acc_valid && !take) ? acc_ident[11:0] : 12'h000) | msg_live};
         if (!acc_valid || take)
            acc_src <= pick_source(msg_live);
      end else if (take) begin
         acc_valid <= 1'b0;
      end
   end

   // log writer: request, two word writes, release, then message irq
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= ilc_pkg::LOG_IDLE;
         // the pointer field is cut off on purpose; only the base bits remain
         ring_base <= 11'(`ILC_LOG_PTR_RESET >> `ILC_RING_LSB);
         ring_ptr <= `ILC_RING_STEP - `ILC_RING_STEP;
         rec_ident <= `ILC_PEND_RESET;
         rec_src <= `ILC_PEND_RESET;
         dma_req_n <= 1'b1;
         mem_wr_n <= 1'b1;
         mem_addr <= `ILC_PEND_RESET;
         mem_data <= `ILC_PEND_RESET;
         log_done <= 1'b0;
      end else begin
         log_done <= 1'b0;
         // software sets the base; the pointer field takes what is written
         if (do_write && wr_addr == `ILC_ADDR_LOG_PTR) begin
            if (wr_strb[1])
               ring_base[10:3] <= wr_data[15:8];
            if (wr_strb[0])
               {ring_base[2:0], ring_ptr} <= wr_data[7:0];
         end
         unique case (state)
            ilc_pkg::LOG_IDLE: begin
               if (take) begin
                  rec_ident <= acc_ident;
                  rec_src <= acc_src;
                  dma_req_n <= 1'b0;
                  state <= ilc_pkg::LOG_REQ;
               end
            end
            ilc_pkg::LOG_REQ: begin
               if (!grant_s) begin
                  mem_addr <= {ring_base, ring_ptr};
                  mem_data <= rec_ident;
                  mem_wr_n <= 1'b0;
                  ring_ptr <= ring_ptr + `ILC_RING_STEP;
                  state <= ilc_pkg::LOG_IDENT;
               end
            end
            ilc_pkg::LOG_IDENT: begin
               mem_addr <= {ring_base, ring_ptr};
               mem_data <= rec_src;
               ring_ptr <= ring_ptr + `ILC_RING_STEP;
               state <= ilc_pkg::LOG_SRC;
            end
            ilc_pkg::LOG_SRC: begin
               mem_wr_n <= 1'b1;
               dma_req_n <= 1'b1;
               state <= ilc_pkg::LOG_REL;
            end
            ilc_pkg::LOG_REL: begin
               // grant must drop before the message interrupt goes out
               if (grant_s) begin
                  log_done <= 1'b1;
                  state <= ilc_pkg::LOG_IDLE;
               end
            end
            default: state <= ilc_pkg::LOG_IDLE;
         endcase
      end
   end

   // one output stage per interrupt: pulse for one cycle, or hold for ack
   for (genvar i = 0; i < 2; i++) begin : g_irq
      always_ff @(posedge clk) begin
         if (!rstn)
            irq_q[i] <= 1'b1;
         else if (fire[i])
            irq_q[i] <= 1'b0;
         else if (!level_mode || !ack_s[i])
            irq_q[i] <= 1'b1;
      end
   end
   assign hw_fail_irq_n = irq_q[1];
   assign msg_irq_n = irq_q[0];

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence two_words_s;
      !mem_wr_n ##1 !mem_wr_n ##1 mem_wr_n;
   endsequence

   hw_pulse_a: assert property (!level_mode && !hw_fail_irq_n && !fire[1] |=> hw_fail_irq_n)
      else $error("failure pulse longer than one cycle");
   hw_no_repulse_a: assert property (pending[15:12] != 4'h0 |=> !$fell(hw_fail_irq_n))
      else $error("failure irq pulsed again while pending");
   msg_after_grant_a: assert property ($fell(msg_irq_n) && $past(log_en, 2) |-> $past(grant_s))
      else $error("message irq before grant release");
   log_words_a: assert property ($fell(mem_wr_n) |-> two_words_s)
      else $error("log record is not two words");
   ring_step_a: assert property ($fell(mem_wr_n) |=> ring_ptr == $past(ring_ptr, 2) +
      `ILC_RING_REC)
      else $error("ring pointer did not advance by two");
   word_order_a: assert property ($fell(mem_wr_n) |=> mem_addr == $past(mem_addr) + 16'h0001)
      else $error("source word not after ident word");
   ident_unused_a: assert property (!mem_wr_n && $past(mem_wr_n) |->
      mem_data[15:12] == 4'h0 && !mem_data[6])
      else $error("unused ident bits set");
   pend_sticky_a: assert property (pend_clr == 16'h0000 |=> (pending & $past(pending)) ==
      $past(pending))
      else $error("pending bit lost without clear");
   mask_block_a: assert property (!level_mode && hw_live == 4'h0 |=> hw_fail_irq_n)
      else $error("masked failure raised irq");
   level_hold_a: assert property (level_mode && !msg_irq_n && ack_s[0] |=> !msg_irq_n)
      else $error("level irq dropped without ack");
   log_capture_a: assert property (log_en && msg_live != 12'h000 |=> acc_valid ||
      state == ilc_pkg::LOG_REQ)
      else $error("message event not queued for logging");
endmodule // interrupt_log_controller
`default_nettype wire

/* File: test/ilc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// shared memory and bus arbiter on the far side of the log writer
module ilc_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] grant_delay, // cycles of stall before grant
   input wire logic dma_req_n,
   output logic dma_grant_in_n,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_data,
   input wire logic mem_wr_n
);
   logic [15:0] mem [0:65535]; // full 64k word space
   logic [3:0] cnt; // stall counter
   // grant follows request after a stall; released pin idles high
   always @(posedge clk) begin
      if (!rstn) begin
         cnt <= 4'h0;
         dma_grant_in_n <= 1'b1;
      end else if (dma_req_n) begin
         cnt <= 4'h0;
         dma_grant_in_n <= 1'b1;
      end else if (cnt >= grant_delay) begin
         dma_grant_in_n <= 1'b0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // one word stored per low write strobe
   always @(posedge clk) begin
      if (rstn && !mem_wr_n) begin
         mem[mem_addr] <= mem_data;
      end
   end
endmodule // ilc_mem_model
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ilc_params.svh"
module testbench;
   logic clk, rstn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, hw_fail_evt, grant_delay;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [11:0] msg_evt;
   logic remote_terminal_mode, bus_controller_mode, monitor_mode;
   logic [15:0] rt_desc_addr, bc_block_addr, mon_count, mem_addr, mem_data;
   logic dma_req_n, dma_grant_in_n, mem_wr_n, hw_fail_irq_n, msg_irq_n;
   logic hw_fail_ack_n, n_a, irq_output_style_sel;
   logic [31:0] rd, exp_src;
   int err_count, compares, hc, mc, k, b, n;
   int bits [11] = '{11, 10, 9, 8, 7, 5, 4, 3, 2, 1, 0};
   interrupt_log_controller u_dut (
      .clk(clk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .hw_fail_evt(hw_fail_evt), .msg_evt(msg_evt),
      .remote_terminal_mode(remote_terminal_mode),
      .bus_controller_mode(bus_controller_mode), .monitor_mode(monitor_mode),
      .rt_desc_addr(rt_desc_addr), .bc_block_addr(bc_block_addr), .mon_count(mon_count),
      .dma_req_n(dma_req_n), .dma_grant_in_n(dma_grant_in_n),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_wr_n(mem_wr_n),
      .hw_fail_irq_n(hw_fail_irq_n), .msg_irq_n(msg_irq_n),
      .hw_fail_ack_n(hw_fail_ack_n), .n_a(n_a),
      .irq_output_style_sel(irq_output_style_sel)
   );
   ilc_mem_model u_mem (.clk(clk), .rstn(rstn), .grant_delay(grant_delay),
      .dma_req_n(dma_req_n), .dma_grant_in_n(dma_grant_in_n),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_wr_n(mem_wr_n));
   // free running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // verdict and end of run
   task summarize;
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a wait bound that ran out ends the run
   task hang;
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
      summarize();
   endtask
   // handshakes sampled on the falling edge, acted on at the next rising one
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (n == 40) hang();
   endtask
   task axi_rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n == 40) hang();
   endtask
   // one-cycle event strobes from the message engine
   task pulse(input logic [3:0] h, input logic [11:0] m);
      @(posedge clk);
      hw_fail_evt <= h; msg_evt <= m;
      @(posedge clk);
      hw_fail_evt <= 4'h0; msg_evt <= 12'h000;
   endtask
   // counts the cycles each irq output is low
   task watch(input int cyc);
      hc = 0; mc = 0;
      repeat (cyc) begin
         @(negedge clk);
         if (hw_fail_irq_n === 1'b0) hc++;
         if (msg_irq_n === 1'b0) mc++;
      end
   endtask
   initial begin
      rstn = 1'b0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0; hw_fail_evt = 4'h0; msg_evt = 12'h000;
      remote_terminal_mode = 1'b0; bus_controller_mode = 1'b0; monitor_mode = 1'b0;
      rt_desc_addr = 16'h0000; bc_block_addr = 16'h0000; mon_count = 16'h0000;
      hw_fail_ack_n = 1'b1; n_a = 1'b1; irq_output_style_sel = 1'b0;
      grant_delay = 4'h0; err_count = 0; compares = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      // register reset values and an unmapped place
      axi_rd(`ILC_ADDR_PEND); check(rd, 32'h0000_0000);
      axi_rd(`ILC_ADDR_LOG_PTR); check(rd, 32'h0000_0000);
      axi_rd(8'h30); check({30'h0, resp}, {30'h0, `ILC_RESP_SLVERR});
      $display("test reset done");
      // failure pulses: one per uncleared pending, masked ones stay silent
      pulse(4'h1, 12'h000); watch(6); check(hc, 1);
      axi_rd(`ILC_ADDR_PEND); check(rd, 32'h0000_1000);
      pulse(4'h2, 12'h000); watch(6); check(hc, 0);
      axi_rd(`ILC_ADDR_PEND); check(rd, 32'h0000_3000);
      axi_wr(`ILC_ADDR_PEND, 32'h0000_3000);
      pulse(4'h4, 12'h000); watch(6); check(hc, 1);
      axi_wr(`ILC_ADDR_PEND, 32'h0000_4000);
      axi_wr(`ILC_ADDR_MASK, 32'h0000_8800);
      pulse(4'h8, 12'h800); watch(6); check(hc + mc, 0);
      axi_rd(`ILC_ADDR_PEND); check(rd, 32'h0000_8800);
      axi_wr(`ILC_ADDR_PEND, 32'h0000_8800);
      axi_wr(`ILC_ADDR_MASK, 32'h0000_0000);
      $display("test failure irq done");
      // level outputs held until the matching acknowledge
      irq_output_style_sel <= 1'b1;
      repeat (4) @(posedge clk);
      pulse(4'h2, 12'h000); watch(6); check(hc, 6);
      // acks change on a rising edge, never in the watch's falling-edge step
      @(posedge clk);
      hw_fail_ack_n <= 1'b0; repeat (4) @(posedge clk); hw_fail_ack_n <= 1'b1;
      watch(4); check(hc, 0);
      pulse(4'h0, 12'h800); watch(6); check(mc, 6);
      @(posedge clk);
      n_a <= 1'b0; repeat (4) @(posedge clk); n_a <= 1'b1;
      watch(4); check(mc, 0);
      @(posedge clk);
      irq_output_style_sel <= 1'b0;
      axi_wr(`ILC_ADDR_PEND, 32'h0000_2800);
      repeat (4) @(posedge clk);
      $display("test level mode done");
      // seventeen records fill the ring and wrap to the start
      axi_wr(`ILC_ADDR_LOG_PTR, 32'h0000_1240);
      check({30'h0, resp}, {30'h0, `ILC_RESP_OKAY});
      axi_wr(`ILC_ADDR_CTRL, 32'h0000_0001);
      for (k = 0; k < 17; k++) begin
         b = bits[k % 11];
         // terminal and monitor run together, so the host must tell them apart
         remote_terminal_mode <= (b >= 7) || (b == 0);
         bus_controller_mode <= (b >= 1 && b <= 5);
         monitor_mode <= (b >= 7) || (b == 0);
         rt_desc_addr <= 16'ha000 + 16'(k);
         bc_block_addr <= 16'hb000 + 16'(k);
         mon_count <= 16'hc000 + 16'(k);
         grant_delay <= (k % 2 == 1) ? 4'h5 : 4'h0;
         exp_src = (b >= 7) ? 32'h0000_a000 + k : (b >= 1) ? 32'h0000_b000 + k
            : 32'h0000_c000 + k;
         pulse(4'h0, 12'(1 << b));
         for (hc = 0; hc < 80 && msg_irq_n !== 1'b0; hc++) @(negedge clk);
         if (hc == 80) hang();
         check({31'h0, dma_grant_in_n}, 32'h0000_0001);
         check(u_mem.mem[16'h1240 + 16'((2 * k) % 32)], 32'(1 << b));
         check(u_mem.mem[16'h1241 + 16'((2 * k) % 32)], exp_src);
         // host side: a source base equal to the descriptor base means terminal
         check({31'h0, u_mem.mem[16'h1241 + 16'((2 * k) % 32)][15:12] == 4'ha},
            {31'h0, b >= 7});
         axi_rd(`ILC_ADDR_LOG_PTR);
         check(rd, 32'h0000_1240 + (2 * (k + 1)) % 32);
         check(rd[4:0] >> 1, (k + 1) % 16);
      end
      $display("test log ring done");
      summarize();
   end
endmodule // testbench
`default_nettype wire
